// ==== design/cgc_clock_control.sv ====
// top of the clock generation and control block
`timescale 1ns/100ps
module cgc_clock_control (
    input  wire logic                             i_clk,
    input  wire logic                             i_rst,
    input  wire logic                             i_por,
    input  wire logic [2:0]                       i_cfg_source,
    input  wire logic [cgc_pkg::ADJUST_WIDTH-1:0] i_factory_adjust,
    input  wire logic                             i_rtc_on_crystal,
    input  wire logic                             i_crystal_in_pin,
    input  wire logic                             i_rc_osc,
    input  wire logic                             i_wdog_osc,
    input  wire logic [7:0]                       i_addr,
    input  wire logic [7:0]                       i_wdata,
    input  wire logic                             i_wr,
    input  wire logic                             i_rd,
    output logic [7:0]                            o_rdata,
    output logic                                  o_osc_source_tick,
    output logic                                  o_cpu_core_clock,
    output logic                                  o_cpu_core_tick,
    output logic                                  o_periph_clock,
    output logic                                  o_machine_cycle,
    output logic                                  o_crystal_out_clock_pin,
    output logic                                  o_crystal_out_clock_oe,
    output logic [cgc_pkg::ADJUST_WIDTH-1:0]      o_internal_rc_adjust,
    output logic                                  o_low_power_clock_select,
    output logic                                  o_xtal_osc_enable,
    output logic [1:0]                            o_xtal_band,
    output logic                                  o_wake_done
);
    import cgc_pkg::*;

    localparam int NUM_OSC = 3;
    localparam int OSC_PIN = 0;
    localparam int OSC_RC  = 1;
    localparam int OSC_WD  = 2;

    // any reset, power-on included
    logic                    any_rst;

    // synchronised oscillator inputs
    logic [NUM_OSC-1:0]      osc_raw;
    logic [NUM_OSC-1:0]      osc_meta;
    logic [NUM_OSC-1:0]      osc_sync;
    logic [NUM_OSC-1:0]      osc_last;
    logic [NUM_OSC-1:0]      osc_rise;

    // captured configuration
    logic [2:0]              cfg_source;
    logic                    crystal_used;
    logic [1:0]              osc_sel;
    logic                    next_osc_tick;
    logic                    next_osc_level;
    logic                    osc_level;

    // software registers
    logic                    clk_out_enable;
    logic [ADJUST_WIDTH-1:0] rc_adjust;
    logic [DIV_WIDTH-1:0]    cpu_clock_divider;
    logic                    low_power_clock_select;
    logic                    next_clk_out_enable;
    logic [ADJUST_WIDTH-1:0] next_rc_adjust;
    logic [DIV_WIDTH-1:0]    next_cpu_clock_divider;
    logic                    next_low_power_clock_select;
    logic [7:0]              next_rdata;

    // divider and wake timer results
    logic                    div_tick;
    logic                    div_level;
    logic                    wake_done;

    // clock tree state
    logic                    run_tick;
    logic                    periph_level;
    logic                    next_periph_level;
    logic                    next_machine_cycle;
    logic                    next_cpu_core_clock;
    logic                    clk_out_allowed;
    logic                    next_out_pin;
    logic                    next_out_oe;

    assign any_rst = i_rst | i_por;
    assign osc_raw = {i_wdog_osc, i_rc_osc, i_crystal_in_pin};

    // two-stage synchronisers and edge detect, one per oscillator input
    genvar g;
    generate
        for (g = 0; g < NUM_OSC; g++) begin : g_osc_sync
            always_ff @(posedge i_clk) begin
                osc_meta[g] <= osc_raw[g];
                osc_sync[g] <= osc_meta[g];
                osc_last[g] <= osc_sync[g];
            end
            assign osc_rise[g] = osc_sync[g] & ~osc_last[g];
        end
    endgenerate

    // configuration is reloaded from the non-volatile bits at each reset
    always_ff @(posedge i_clk) begin
        if (any_rst) begin
            cfg_source <= i_cfg_source;
        end
    end

    // decode the source: three crystal bands, rc, watchdog or external
    always_comb begin
        crystal_used = 1'b0;
        osc_sel      = 2'(OSC_PIN);
        unique case (cfg_source)
            SRC_XTAL_LOW, SRC_XTAL_MED, SRC_XTAL_HIGH: begin
                crystal_used = 1'b1;
                osc_sel      = 2'(OSC_PIN);
            end
            SRC_RC_OSC: begin
                osc_sel = 2'(OSC_RC);
            end
            SRC_WDOG_OSC: begin
                osc_sel = 2'(OSC_WD);
            end
            SRC_EXT_CLOCK: begin
                osc_sel = 2'(OSC_PIN);
            end
            default: begin
                osc_sel = 2'(OSC_RC);
            end
        endcase
    end

    // select exactly one source as the oscillator clock
    always_comb begin
        next_osc_tick  = osc_rise[osc_sel];
        next_osc_level = osc_sync[osc_sel];
    end

    // oscillator clock registers
    always_ff @(posedge i_clk) begin
        if (any_rst) begin
            o_osc_source_tick <= 1'b0;
            osc_level         <= 1'b0;
        end else begin
            o_osc_source_tick <= next_osc_tick;
            osc_level         <= next_osc_level;
        end
    end

    // start-up hold-off of the cpu clock
    cgc_wake_timer u_wake (
        .i_clk          (i_clk),
        .i_rst          (any_rst),
        .i_osc_tick     (o_osc_source_tick),
        .i_crystal_band (crystal_used),
        .o_done         (wake_done)
    );

    // programmable cpu clock divider
    cgc_clock_divider u_div (
        .i_clk       (i_clk),
        .i_rst       (any_rst),
        .i_osc_tick  (o_osc_source_tick),
        .i_osc_level (osc_level),
        .i_divider   (cpu_clock_divider),
        .o_cpu_tick  (div_tick),
        .o_cpu_level (div_level)
    );

    // register writes and read data
    always_comb begin
        next_clk_out_enable         = clk_out_enable;
        next_rc_adjust              = rc_adjust;
        next_cpu_clock_divider      = cpu_clock_divider;
        next_low_power_clock_select = low_power_clock_select;
        next_rdata                  = 8'h00;
        if (i_wr && !any_rst) begin
            unique case (i_addr)
                ADDR_RC_ADJUST: begin
                    next_clk_out_enable = i_wdata[CLK_OUT_ENABLE_BIT];
                    next_rc_adjust      = i_wdata[ADJUST_WIDTH-1:0];
                end
                ADDR_CPU_DIVIDER: begin
                    next_cpu_clock_divider = i_wdata;
                end
                ADDR_AUX_CONTROL: begin
                    next_low_power_clock_select = i_wdata[LOW_POWER_BIT];
                end
                default: begin
                    next_rdata = 8'h00;
                end
            endcase
        end
        if (i_rd) begin
            unique case (i_addr)
                ADDR_RC_ADJUST: begin
                    next_rdata = {1'b0, clk_out_enable, rc_adjust};
                end
                ADDR_CPU_DIVIDER: begin
                    next_rdata = cpu_clock_divider;
                end
                ADDR_AUX_CONTROL: begin
                    next_rdata = {low_power_clock_select, 7'h00};
                end
                ADDR_STATUS: begin
                    next_rdata = {2'h0, o_crystal_out_clock_oe, crystal_used, cfg_source, wake_done};
                end
                default: begin
                    next_rdata = 8'h00;
                end
            endcase
        end
    end

    // adjust register follows power-on reset only
    always_ff @(posedge i_clk) begin
        if (i_por) begin
            rc_adjust      <= i_factory_adjust;
            clk_out_enable <= RST_CLK_OUT_ENABLE;
        end else begin
            rc_adjust      <= next_rc_adjust;
            clk_out_enable <= next_clk_out_enable;
        end
    end

    // divider and auxiliary registers follow every reset
    always_ff @(posedge i_clk) begin
        if (any_rst) begin
            cpu_clock_divider      <= RST_CPU_DIVIDER;
            low_power_clock_select <= RST_LOW_POWER;
            o_rdata                <= 8'h00;
        end else begin
            cpu_clock_divider      <= next_cpu_clock_divider;
            low_power_clock_select <= next_low_power_clock_select;
            o_rdata                <= next_rdata;
        end
    end

    // cpu clock, peripheral clock, machine cycle and clock output
    always_comb begin
        run_tick            = div_tick & wake_done;
        next_cpu_core_clock = div_level & wake_done;
        next_periph_level   = periph_level ^ run_tick;
        next_machine_cycle  = run_tick & periph_level;
        clk_out_allowed     = clk_out_enable & ~crystal_used & ~i_rtc_on_crystal;
        next_out_oe         = clk_out_allowed;
        next_out_pin        = clk_out_allowed & next_periph_level;
    end

    // clock tree output registers
    always_ff @(posedge i_clk) begin
        if (any_rst) begin
            periph_level            <= 1'b0;
            o_periph_clock          <= 1'b0;
            o_machine_cycle         <= 1'b0;
            o_cpu_core_clock        <= 1'b0;
            o_cpu_core_tick         <= 1'b0;
            o_crystal_out_clock_pin <= 1'b0;
            o_crystal_out_clock_oe  <= 1'b0;
        end else begin
            periph_level            <= next_periph_level;
            o_periph_clock          <= next_periph_level;
            o_machine_cycle         <= next_machine_cycle;
            o_cpu_core_clock        <= next_cpu_core_clock;
            o_cpu_core_tick         <= run_tick;
            o_crystal_out_clock_pin <= next_out_pin;
            o_crystal_out_clock_oe  <= next_out_oe;
        end
    end

    // rc adjust output towards the internal rc oscillator, reset by power-on only
    always_ff @(posedge i_clk) begin
        if (i_por) begin
            o_internal_rc_adjust <= i_factory_adjust;
        end else begin
            o_internal_rc_adjust <= next_rc_adjust;
        end
    end

    // source and mode outputs
    always_ff @(posedge i_clk) begin
        if (any_rst) begin
            o_low_power_clock_select <= RST_LOW_POWER;
            o_xtal_osc_enable        <= 1'b0;
            o_xtal_band              <= 2'h0;
            o_wake_done              <= 1'b0;
        end else begin
            o_low_power_clock_select <= next_low_power_clock_select;
            o_xtal_osc_enable        <= crystal_used | i_rtc_on_crystal;
            o_xtal_band              <= cfg_source[1:0];
            o_wake_done              <= wake_done;
        end
    end
endmodule

// ==== design/cgc_clock_divider.sv ====
// divider that makes the cpu clock from oscillator ticks
`timescale 1ns/100ps
module cgc_clock_divider (
    input  wire logic                         i_clk,
    input  wire logic                         i_rst,
    input  wire logic                         i_osc_tick,
    input  wire logic                         i_osc_level,
    input  wire logic [cgc_pkg::DIV_WIDTH-1:0] i_divider,
    output logic                              o_cpu_tick,
    output logic                              o_cpu_level
);
    import cgc_pkg::*;

    logic [DIV_WIDTH-1:0] active_div;
    logic [DIV_WIDTH:0]   count;
    logic [DIV_WIDTH-1:0] next_active_div;
    logic [DIV_WIDTH:0]   next_count;
    logic                 next_cpu_tick;
    logic                 next_cpu_level;

    // count oscillator ticks; a period ends after twice the ratio
    always_comb begin
        next_active_div = active_div;
        next_count      = count;
        next_cpu_tick   = 1'b0;
        next_cpu_level  = o_cpu_level;
        if (active_div == '0) begin
            next_cpu_level = i_osc_level;
            next_cpu_tick  = i_osc_tick;
            if (i_osc_tick) begin
                next_active_div = i_divider;
                next_count      = '0;
            end
        end else if (i_osc_tick) begin
            if (count == (DIV_WIDTH+1)'({active_div, 1'b0} - 9'd1)) begin
                next_count      = '0;
                next_cpu_tick   = 1'b1;
                next_cpu_level  = 1'b1;
                next_active_div = i_divider;
            end else begin
                next_count = (DIV_WIDTH+1)'(count + 9'd1);
                if ((DIV_WIDTH+1)'(count + 9'd1) == {1'b0, active_div}) begin
                    next_cpu_level = 1'b0;
                end
            end
        end
    end

    // divider state registers
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            active_div  <= RST_CPU_DIVIDER;
            count       <= '0;
            o_cpu_tick  <= 1'b0;
            o_cpu_level <= 1'b0;
        end else begin
            active_div  <= next_active_div;
            count       <= next_count;
            o_cpu_tick  <= next_cpu_tick;
            o_cpu_level <= next_cpu_level;
        end
    end
endmodule

// ==== design/cgc_pkg.sv ====
// package of constants for the clock generation and control block
package cgc_pkg;
    // register offsets on the software port
    localparam logic [7:0] ADDR_RC_ADJUST     = 8'h96;
    localparam logic [7:0] ADDR_CPU_DIVIDER   = 8'hA0;
    localparam logic [7:0] ADDR_AUX_CONTROL   = 8'hA1;
    localparam logic [7:0] ADDR_STATUS        = 8'hA2;
    // field positions
    localparam int         CLK_OUT_ENABLE_BIT = 6;
    localparam int         ADJUST_WIDTH       = 6;
    localparam int         LOW_POWER_BIT      = 7;
    // values after reset
    localparam logic [7:0] RST_CPU_DIVIDER    = 8'h00;
    localparam logic       RST_LOW_POWER      = 1'b0;
    localparam logic       RST_CLK_OUT_ENABLE = 1'b0;
    // configuration codes of the oscillator source
    localparam logic [2:0] SRC_XTAL_LOW       = 3'h0;
    localparam logic [2:0] SRC_XTAL_MED       = 3'h1;
    localparam logic [2:0] SRC_XTAL_HIGH      = 3'h2;
    localparam logic [2:0] SRC_RC_OSC         = 3'h3;
    localparam logic [2:0] SRC_WDOG_OSC       = 3'h4;
    localparam logic [2:0] SRC_EXT_CLOCK      = 3'h5;
    // wake-up delay
    localparam int         CLK_PERIOD_NS      = 25;
    localparam int         WAKE_XTAL_OSC_CYC  = 992;
    localparam int         WAKE_OTHER_OSC_CYC = 224;
    localparam int         WAKE_EXTRA_US      = 60;
    localparam int         WAKE_EXTRA_CYC     = (WAKE_EXTRA_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int         WAKE_CNT_WIDTH     = 12;
    // divider ratio limit
    localparam int         MAX_DIV_RATIO      = 510;
    localparam int         DIV_WIDTH          = 8;
endpackage

// ==== design/cgc_wake_timer.sv ====
// wake-up timer that holds the cpu clock off after start-up
`timescale 1ns/100ps
module cgc_wake_timer (
    input  wire logic i_clk,
    input  wire logic i_rst,
    input  wire logic i_osc_tick,
    input  wire logic i_crystal_band,
    output logic      o_done
);
    import cgc_pkg::*;

    typedef enum logic [1:0] {ST_OSC, ST_EXTRA, ST_DONE} cgc_wake_state_t;

    cgc_wake_state_t           state;
    cgc_wake_state_t           next_state;
    logic [WAKE_CNT_WIDTH-1:0] count;
    logic [WAKE_CNT_WIDTH-1:0] next_count;
    logic [WAKE_CNT_WIDTH-1:0] osc_limit;

    // oscillator cycles first, then the fixed settling time
    always_comb begin
        osc_limit  = i_crystal_band ? WAKE_CNT_WIDTH'(WAKE_XTAL_OSC_CYC - 1)
                                    : WAKE_CNT_WIDTH'(WAKE_OTHER_OSC_CYC - 1);
        next_state = state;
        next_count = count;
        unique case (state)
            ST_OSC: begin
                if (i_osc_tick) begin
                    if (count == osc_limit) begin
                        next_state = ST_EXTRA;
                        next_count = '0;
                    end else begin
                        next_count = WAKE_CNT_WIDTH'(count + 12'd1);
                    end
                end
            end
            ST_EXTRA: begin
                if (count == WAKE_CNT_WIDTH'(WAKE_EXTRA_CYC - 1)) begin
                    next_state = ST_DONE;
                end else begin
                    next_count = WAKE_CNT_WIDTH'(count + 12'd1);
                end
            end
            ST_DONE: begin
                next_state = ST_DONE;
            end
        endcase
    end

    // timer registers
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            state  <= ST_OSC;
            count  <= '0;
            o_done <= 1'b0;
        end else begin
            state  <= next_state;
            count  <= next_count;
            o_done <= (next_state == ST_DONE);
        end
    end
endmodule

// ==== tb/cgc_clock_control_assertions.sv ====
// concurrent checks on the ports of the clock generation and control top
`timescale 1ns/100ps
module cgc_clock_control_assertions
    import cgc_pkg::*;
(
    input wire logic       i_clk,
    input wire logic       i_rst,
    input wire logic       i_por,
    input wire logic [7:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic       i_wr,
    input wire logic       i_rd,
    input wire logic [7:0] o_rdata,
    input wire logic       o_osc_source_tick,
    input wire logic       o_cpu_core_clock,
    input wire logic       o_cpu_core_tick,
    input wire logic       o_periph_clock,
    input wire logic       o_machine_cycle,
    input wire logic       o_crystal_out_clock_pin,
    input wire logic       o_crystal_out_clock_oe,
    input wire logic [5:0] o_internal_rc_adjust,
    input wire logic       o_low_power_clock_select,
    input wire logic       o_xtal_osc_enable,
    input wire logic       o_wake_done
);
    logic        rst_any;
    logic        tick_phase;
    logic [15:0] tick_cnt;
    logic [15:0] cyc_cnt;
    assign rst_any = i_rst | i_por;
    // pairing phase of cpu ticks, and osc ticks and cycles seen before wake-up
    always_ff @(posedge i_clk) begin
        if (rst_any) begin
            tick_phase <= 1'b0;
            tick_cnt   <= 16'h0000;
            cyc_cnt    <= 16'h0000;
        end else begin
            tick_phase <= tick_phase ^ o_cpu_core_tick;
            tick_cnt   <= tick_cnt + 16'(o_osc_source_tick & ~o_wake_done);
            cyc_cnt    <= cyc_cnt + 16'(~o_wake_done);
        end
    end
    default clocking @(posedge i_clk); endclocking
    default disable iff (rst_any);
    wake_gate_a: assert property (!o_wake_done |-> !o_cpu_core_tick && !o_cpu_core_clock)
        else $error("cpu clock active before wake-up");
    wake_count_a: assert property ($rose(o_wake_done) |-> cyc_cnt >= WAKE_EXTRA_CYC
        && tick_cnt >= (o_xtal_osc_enable ? 16'd992 : 16'd224)) else $error("wake-up came too early");
    wake_hold_a: assert property (o_wake_done |=> o_wake_done)
        else $error("wake-up flag dropped without reset");
    periph_half_a: assert property ((o_periph_clock != $past(o_periph_clock)) == o_cpu_core_tick)
        else $error("peripheral clock not toggling once per cpu tick");
    machine_pair_a: assert property (o_machine_cycle == (o_cpu_core_tick && tick_phase))
        else $error("machine cycle not on every second cpu tick");
    clkout_gate_a: assert property (o_xtal_osc_enable |-> !o_crystal_out_clock_oe)
        else $error("clock out driven while crystal in use");
    clkout_level_a: assert property (o_crystal_out_clock_oe |-> o_crystal_out_clock_pin == o_periph_clock)
        else $error("clock out level differs from half cpu clock");
    rdata_idle_a: assert property (!$past(i_rd) |-> o_rdata == 8'h00)
        else $error("read data present without a read");
    lowpwr_reset_a: assert property ($fell(rst_any) |-> !o_low_power_clock_select)
        else $error("low-power select not cleared by reset");
    lowpwr_write_a: assert property (i_wr && i_addr == ADDR_AUX_CONTROL
        |=> o_low_power_clock_select == $past(i_wdata[7])) else $error("low-power select write lost");
    adjust_write_a: assert property (i_wr && i_addr == ADDR_RC_ADJUST
        |=> {2'b00, o_internal_rc_adjust} == ($past(i_wdata) & 8'h3F)) else $error("rc adjust write lost");
    cpu_tick_high_a: assert property (o_cpu_core_tick |-> o_cpu_core_clock)
        else $error("cpu tick outside the high phase of the cpu clock");
endmodule

// ==== tb/cgc_osc_model.sv ====
// behavioural model of the oscillator sources feeding the clock block
`timescale 1ns/100ps
module cgc_osc_model #(
    parameter int RC_HALF_NS = 50,
    parameter int WD_HALF_NS = 75,
    parameter int XT_HALF_NS = 100
) (
    input  wire logic i_xtal_run,
    output logic      o_crystal_in,
    output logic      o_rc,
    output logic      o_wdog
);
    // on-chip rc oscillator, free running, off the clock grid
    initial begin
        o_rc = 1'b0;
        #7;
        forever #(RC_HALF_NS) o_rc = ~o_rc;
    end
    // separate slow watchdog oscillator, usable as main source
    initial begin
        o_wdog = 1'b0;
        #7;
        forever #(WD_HALF_NS) o_wdog = ~o_wdog;
    end
    // crystal or external clock; stands low while not running
    initial begin
        o_crystal_in = 1'b0;
        #11;
        forever begin
            #(XT_HALF_NS);
            o_crystal_in = i_xtal_run ? ~o_crystal_in : 1'b0;
        end
    end
endmodule

// ==== tb/tb.sv ====
// self-checking bench for the clock generation and control block
`timescale 1ns/100ps
module tb;
    import cgc_pkg::*;
    localparam logic [5:0] FACTORY = 6'h2A;
    localparam int         TIMEOUT = 90000;
    logic       i_clk, i_rst, i_por, i_rtc_on_crystal, i_wr, i_rd;
    logic       i_crystal_in_pin, i_rc_osc, i_wdog_osc, xtal_run;
    logic [2:0] i_cfg_source;
    logic [5:0] i_factory_adjust, o_internal_rc_adjust;
    logic [7:0] i_addr, i_wdata, o_rdata;
    logic       o_osc_source_tick, o_cpu_core_clock, o_cpu_core_tick, o_periph_clock, o_machine_cycle;
    logic       o_crystal_out_clock_pin, o_crystal_out_clock_oe, o_low_power_clock_select;
    logic       o_xtal_osc_enable, o_wake_done;
    logic [1:0] o_xtal_band;
    int         err_count = 0;
    int         n_checks  = 0;
    int         cycles    = 0;
    int         g;
    logic [7:0] divs [4] = '{8'h00, 8'h01, 8'h03, 8'hFF};
    int         pers [8] = '{8, 8, 8, 4, 6, 8, 4, 4};

    // the crystal only oscillates while its amplifier is on; an external source runs in its mode
    assign xtal_run = o_xtal_osc_enable | (i_cfg_source == SRC_EXT_CLOCK);

    cgc_clock_control dut_u (.i_clk, .i_rst, .i_por, .i_cfg_source, .i_factory_adjust, .i_rtc_on_crystal,
        .i_crystal_in_pin, .i_rc_osc, .i_wdog_osc, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata,
        .o_osc_source_tick, .o_cpu_core_clock, .o_cpu_core_tick, .o_periph_clock, .o_machine_cycle,
        .o_crystal_out_clock_pin, .o_crystal_out_clock_oe, .o_internal_rc_adjust,
        .o_low_power_clock_select, .o_xtal_osc_enable, .o_xtal_band, .o_wake_done);
    cgc_osc_model osc_u (.i_xtal_run(xtal_run), .o_crystal_in(i_crystal_in_pin), .o_rc(i_rc_osc),
        .o_wdog(i_wdog_osc));

    // verdict and end of run
    task automatic finish_test();
        if (err_count == 0 && n_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // one-cycle register write
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_clk);
        i_wr    <= 1'b1;
        i_addr  <= a;
        i_wdata <= d;
        @(posedge i_clk);
        i_wr    <= 1'b0;
    endtask
    // one-cycle read, data taken in the following cycle
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        @(posedge i_clk);
        i_rd   <= 1'b1;
        i_addr <= a;
        @(posedge i_clk);
        i_rd   <= 1'b0;
        #1;
        check(16'(o_rdata), 16'(exp));
    endtask
    task automatic do_reset(input logic por, input logic [2:0] src);
        @(posedge i_clk);
        i_cfg_source <= src;
        i_rst        <= ~por;
        i_por        <= por;
        repeat (4) @(posedge i_clk);
        i_rst <= 1'b0;
        i_por <= 1'b0;
    endtask
    // cycles from reset release to wake-up against the osc period in cycles
    task automatic wait_wake(input int per, input int ticks);
        int n;
        int lo;
        n  = 0;
        lo = ticks * per + WAKE_EXTRA_CYC;
        while (o_wake_done !== 1'b1 && n < 20000) begin
            @(posedge i_clk);
            #1;
            n++;
        end
        check(16'(n >= lo - per && n <= lo + 8 * per), 16'h0001);
    endtask
    // cycles until the next cpu tick
    task automatic next_tick(output int n);
        n = 0;
        do begin
            @(posedge i_clk);
            #1;
            n++;
        end while (o_cpu_core_tick !== 1'b1 && n < 3000);
    endtask
    task automatic settle_oe(input logic exp);
        repeat (3) @(posedge i_clk);
        #1;
        check(16'(o_crystal_out_clock_oe), 16'(exp));
    endtask

    // clock at 40 MHz
    initial begin
        i_clk = 1'b0;
        forever #12.5 i_clk = ~i_clk;
    end
    // hang guard
    always @(posedge i_clk) begin
        cycles <= cycles + 1;
        if (cycles == TIMEOUT) begin
            err_count++;
            finish_test();
        end
    end
    // main sequence
    initial begin
        i_rst = 1'b1;
        i_por = 1'b1;
        i_rtc_on_crystal = 1'b0;
        i_cfg_source = SRC_RC_OSC;
        i_factory_adjust = FACTORY;
        i_addr = 8'h00;
        i_wdata = 8'h00;
        i_wr = 1'b0;
        i_rd = 1'b0;
        do_reset(1'b1, SRC_RC_OSC);
        wait_wake(4, WAKE_OTHER_OSC_CYC);
        rd_chk(ADDR_RC_ADJUST, {2'b00, FACTORY});
        rd_chk(ADDR_CPU_DIVIDER, RST_CPU_DIVIDER);
        rd_chk(ADDR_AUX_CONTROL, 8'h00);
        rd_chk(8'h55, 8'h00);
        wr(ADDR_STATUS, 8'hFF);
        rd_chk(ADDR_STATUS, {4'h0, SRC_RC_OSC, 1'b1});
        wr(ADDR_AUX_CONTROL, 8'h80);
        rd_chk(ADDR_AUX_CONTROL, 8'h80);
        wr(ADDR_RC_ADJUST, 8'hD5);
        rd_chk(ADDR_RC_ADJUST, 8'h55);
        settle_oe(1'b1);
        rd_chk(ADDR_STATUS, 8'h27);
        @(posedge i_clk);
        i_rtc_on_crystal <= 1'b1;
        settle_oe(1'b0);
        @(posedge i_clk);
        i_rtc_on_crystal <= 1'b0;
        // ratio changes on the fly; the last gap shows the new period
        foreach (divs[k]) begin
            wr(ADDR_CPU_DIVIDER, divs[k]);
            repeat (4) next_tick(g);
            check(16'(g), 16'(divs[k] == 8'h00 ? 4 : 8 * int'(divs[k])));
        end
        // a plain reset keeps the adjust register and clears low-power select
        do_reset(1'b0, SRC_WDOG_OSC);
        wait_wake(6, WAKE_OTHER_OSC_CYC);
        rd_chk(ADDR_RC_ADJUST, 8'h55);
        rd_chk(ADDR_AUX_CONTROL, 8'h00);
        // every configured source from power-on; codes 6 and 7 fall back to the rc oscillator
        for (int s = 0; s < 8; s++) begin
            do_reset(1'b1, 3'(s));
            wait_wake(pers[s], s < 3 ? WAKE_XTAL_OSC_CYC : WAKE_OTHER_OSC_CYC);
            check(16'({o_xtal_osc_enable, o_xtal_band}), 16'({s < 3, 2'(s)}));
            rd_chk(ADDR_RC_ADJUST, {2'b00, FACTORY});
            wr(ADDR_RC_ADJUST, {2'b01, FACTORY});
            settle_oe(s >= 3);
        end
        finish_test();
    end
endmodule

bind cgc_clock_control cgc_clock_control_assertions chk_u (.i_clk, .i_rst, .i_por, .i_addr, .i_wdata, .i_wr,
    .i_rd, .o_rdata, .o_osc_source_tick, .o_cpu_core_clock, .o_cpu_core_tick, .o_periph_clock, .o_machine_cycle,
    .o_crystal_out_clock_pin, .o_crystal_out_clock_oe, .o_internal_rc_adjust, .o_low_power_clock_select,
    .o_xtal_osc_enable, .o_wake_done);
